/* hw/ecc_cmd_top.sv */
`timescale 1ns/100ps
// Contract
// - result of primitive operations goes to slot given by config bits 20:16
// - operand B is fetched from slot given by config bits 12:8
// - operand A is fetched from slot given by config bits 4:0
// - command bit 31 set forces R mod N first; hardware clears it; writing 0 does nothing
// - command bit 30 marks curve parameter B negative
// - command bit 29 marks curve parameter A negative
// - command bits 15:8 give operand length in 64-bit words
// - operand length is bounded by a build-time storage parameter
// - command bit 7 selects prime field (0) or binary field (1)
// - start is sampled on the clock, ignored while busy, cleared at finish
// - command bits 6:0 pick the operation; 1 is modular add, 2 modular subtract
`include "ecc_defs.svh"
module ecc_cmd_top import ecc_pkg::*; #(
  parameter int MAX_OPERAND_SIZE_PARAM = `ECC_MAX_LOG2_DEF,
  parameter logic [31:0] VERSION_ID = `ECC_VERSION_DEF, // arbitrary value
  localparam int AW = 5 + MAX_OPERAND_SIZE_PARAM
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [31:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic ld_en_i,
  input wire logic ld_we_i,
  input wire logic [AW-1:0] ld_addr_i,
  input wire logic [63:0] ld_wdata_i,
  output logic [63:0] ld_rdata_o,
  output logic busy_o,
  output logic curve_param_a_negative_o,
  output logic curve_param_b_negative_o,
  output logic field_binary_o
);
  localparam int LW = MAX_OPERAND_SIZE_PARAM;
  localparam logic [8:0] MAXW = 9'(1 << MAX_OPERAND_SIZE_PARAM);

  // the word count is eight bits wide, so storage above 255 words is unusable
  if (MAX_OPERAND_SIZE_PARAM < 1 || MAX_OPERAND_SIZE_PARAM > 7) begin : g_bad_size
    $error("MAX_OPERAND_SIZE_PARAM must lie in 1..7");
  end

  ecc_state_t st_reg;
  ecc_state_t st_next;
  ecc_mem_if #(.AW(AW)) mem_bus ();
  logic req;
  logic acc;
  logic [31:0] config_rd;
  logic [31:0] command_rd;
  logic [31:0] status_rd;
  logic [31:0] wmerged;
  logic [31:0] cfg_w;
  logic [31:0] cmd_w;
  logic [4:0] slot_a;
  logic [4:0] slot_b;
  logic [4:0] slot_c;
  logic sub_mode;
  logic xor_mode;
  logic last_word;
  logic size_ok;
  logic op_ok;
  logic use_d;
  logic [15:0] dbl_last;
  logic [63:0] s_word;
  logic s_cout;
  logic [63:0] d_word;
  logic d_cout;

  ecc_mem #(.AW(AW)) u_mem (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .eng(mem_bus.mem),
    .ld_en_i(ld_en_i),
    .ld_we_i(ld_we_i),
    .ld_addr_i(ld_addr_i),
    .ld_wdata_i(ld_wdata_i),
    .ld_rdata_o(ld_rdata_o)
  );

  // first limb chain: A op B
  ecc_word_alu #(.W(64)) u_alu_s (
    .a_i(st_reg.op_a),
    .b_i(st_reg.op_b),
    .cin_i(st_reg.carry_s),
    .sub_i(sub_mode),
    .xor_i(xor_mode),
    .y_o(s_word),
    .cout_o(s_cout)
  );

  // second chain: the corrected candidate, S minus N on add, S plus N on subtract
  ecc_word_alu #(.W(64)) u_alu_d (
    .a_i(s_word),
    .b_i(mem_bus.rdata),
    .cin_i(st_reg.carry_d),
    .sub_i(!sub_mode),
    .xor_i(1'b0),
    .y_o(d_word),
    .cout_o(d_cout)
  );

  // bus handshake: one wait state, then the access completes
  assign req = avs_read_i | avs_write_i;
  assign acc = req & st_reg.ack & ce_i;
  assign avs_waitrequest_o = req & !(st_reg.ack & ce_i);
  assign avs_readdata_o = st_reg.rdata;

  // readback images, reserved bits tied low
  assign config_rd = {11'h000, st_reg.ptr_c, 3'h0, st_reg.ptr_b, 3'h0, st_reg.ptr_a};
  assign command_rd = {st_reg.calc_req, st_reg.sign_b, st_reg.sign_a, 13'h0000,
                       st_reg.words, st_reg.field, st_reg.opcode};
  assign status_rd = {28'h0000000, st_reg.err_size, st_reg.err_op, st_reg.done,
                      (st_reg.st != ST_IDLE)};

  // byte-lane merge of write data into the current image
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmerged[8*i +: 8] = avs_byteenable_i[i] ? avs_writedata_i[8*i +: 8] : 8'h00;
    end
  end
  assign cfg_w = ((wmerged & {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                   {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}})
                  | (config_rd & ~{{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                   {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}}))
                 & `ECC_CFG_MASK;
  assign cmd_w = ((wmerged & {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                   {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}})
                  | (command_rd & ~{{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                   {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}}))
                 & `ECC_CMD_MASK;

  // slot selection; the modulus pass doubles its own slot in place
  assign slot_a = st_reg.rmod_phase ? `ECC_SLOT_RMOD : st_reg.ptr_a;
  assign slot_b = st_reg.rmod_phase ? `ECC_SLOT_RMOD : st_reg.ptr_b;
  assign slot_c = st_reg.rmod_phase ? `ECC_SLOT_RMOD : st_reg.ptr_c;
  assign sub_mode = !st_reg.rmod_phase && (st_reg.opcode == `ECC_OP_MOD_SUB);
  assign xor_mode = !st_reg.rmod_phase && st_reg.field;
  assign last_word = (st_reg.word == st_reg.words - 8'h01);
  assign size_ok = (st_reg.words != 8'h00) && ({1'b0, st_reg.words} <= MAXW);
  assign op_ok = (st_reg.opcode == `ECC_OP_MOD_ADD) || (st_reg.opcode == `ECC_OP_MOD_SUB);
  // add: reduce when the sum overflowed or S-N did not borrow; subtract: on borrow
  assign use_d = xor_mode ? 1'b0 : sub_mode ? st_reg.carry_s
                 : (st_reg.carry_s | !st_reg.carry_d);
  assign dbl_last = 16'(`ECC_BITS_PER_WORD * {8'h00, st_reg.words}) - 16'h0001;

  // memory port driven from the engine state
  always_comb begin
    mem_bus.en = 1'b0;
    mem_bus.we = 1'b0;
    mem_bus.addr = '0;
    mem_bus.wdata = 64'h0;
    unique case (st_reg.st)
      ST_INIT: begin
        mem_bus.en = 1'b1;
        mem_bus.we = 1'b1;
        mem_bus.addr = {`ECC_SLOT_RMOD, st_reg.word[LW-1:0]};
        mem_bus.wdata = (st_reg.word == 8'h00) ? 64'h1 : 64'h0;
      end
      ST_RA: begin
        mem_bus.en = 1'b1;
        mem_bus.addr = {slot_a, st_reg.word[LW-1:0]};
      end
      ST_RB: begin
        mem_bus.en = 1'b1;
        mem_bus.addr = {slot_b, st_reg.word[LW-1:0]};
      end
      ST_RN: begin
        mem_bus.en = 1'b1;
        mem_bus.addr = {`ECC_SLOT_MOD, st_reg.word[LW-1:0]};
      end
      ST_WS: begin
        mem_bus.en = 1'b1;
        mem_bus.we = 1'b1;
        mem_bus.addr = {slot_c, st_reg.word[LW-1:0]};
        mem_bus.wdata = s_word;
      end
      ST_WD: begin
        mem_bus.en = 1'b1;
        mem_bus.we = 1'b1;
        mem_bus.addr = {`ECC_SLOT_SCRATCH, st_reg.word[LW-1:0]};
        mem_bus.wdata = st_reg.d_word;
      end
      ST_CR: begin
        mem_bus.en = 1'b1;
        mem_bus.addr = {`ECC_SLOT_SCRATCH, st_reg.word[LW-1:0]};
      end
      ST_CW: begin
        mem_bus.en = 1'b1;
        mem_bus.we = 1'b1;
        mem_bus.addr = {slot_c, st_reg.word[LW-1:0]};
        mem_bus.wdata = mem_bus.rdata;
      end
      default: begin
        mem_bus.en = 1'b0;
      end
    endcase
  end

  // next state: engine first, then bus writes so a software set beats a clear
  always_comb begin
    st_next = st_reg;
    st_next.ack = req & !st_reg.ack;
    unique case (st_reg.st)
      ST_IDLE: begin
        st_next.st = ST_IDLE;
      end
      ST_DISP: begin
        st_next.word = 8'h00;
        st_next.carry_s = 1'b0;
        st_next.carry_d = 1'b0;
        if (!size_ok) begin
          st_next.err_size = 1'b1;
          st_next.st = ST_FIN;
        end else if (st_reg.calc_req) begin
          st_next.rmod_phase = 1'b1;
          st_next.dbl_cnt = 16'h0000;
          st_next.st = ST_INIT;
        end else if (op_ok) begin
          st_next.st = ST_RA;
        end else begin
          st_next.err_op = 1'b1;
          st_next.st = ST_FIN;
        end
      end
      ST_INIT: begin
        st_next.word = last_word ? 8'h00 : st_reg.word + 8'h01;
        st_next.st = last_word ? ST_RA : ST_INIT;
      end
      ST_RA: st_next.st = ST_RB;
      ST_RB: begin
        st_next.op_a = mem_bus.rdata;
        st_next.st = ST_RN;
      end
      ST_RN: begin
        st_next.op_b = mem_bus.rdata;
        st_next.st = ST_WS;
      end
      ST_WS: begin
        st_next.carry_s = s_cout;
        st_next.carry_d = d_cout;
        st_next.d_word = d_word;
        st_next.st = ST_WD;
      end
      ST_WD: begin
        st_next.word = last_word ? 8'h00 : st_reg.word + 8'h01;
        st_next.st = !last_word ? ST_RA : (use_d ? ST_CR : ST_PEND);
      end
      ST_CR: st_next.st = ST_CW;
      ST_CW: begin
        st_next.word = last_word ? 8'h00 : st_reg.word + 8'h01;
        st_next.st = last_word ? ST_PEND : ST_CR;
      end
      ST_PEND: begin
        st_next.carry_s = 1'b0;
        st_next.carry_d = 1'b0;
        if (!st_reg.rmod_phase) begin
          st_next.st = ST_FIN;
        end else if (st_reg.dbl_cnt == dbl_last) begin
          st_next.rmod_phase = 1'b0;
          st_next.calc_req = 1'b0;
          st_next.st = ST_DISP;
        end else begin
          st_next.dbl_cnt = st_reg.dbl_cnt + 16'h0001;
          st_next.st = ST_RA;
        end
      end
      ST_FIN: begin
        st_next.start = 1'b0;
        st_next.done = 1'b1;
        st_next.st = ST_IDLE;
      end
      default: st_next.st = ST_IDLE;
    endcase
    if (avs_read_i && !st_reg.ack) begin // data stand by the edge where waitrequest drops
      unique case (avs_address_i)
        `ECC_OFS_CONFIG: st_next.rdata = config_rd;
        `ECC_OFS_COMMAND: st_next.rdata = command_rd;
        `ECC_OFS_CONTROL: st_next.rdata = {31'h00000000, st_reg.start};
        `ECC_OFS_STATUS: st_next.rdata = status_rd;
        `ECC_OFS_VERSION: st_next.rdata = VERSION_ID;
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end
    if (acc && avs_write_i) begin
      if (avs_address_i == `ECC_OFS_CONFIG) begin
        st_next.ptr_c = cfg_w[`ECC_CFG_PTR_C_MSB:`ECC_CFG_PTR_C_LSB];
        st_next.ptr_b = cfg_w[`ECC_CFG_PTR_B_MSB:`ECC_CFG_PTR_B_LSB];
        st_next.ptr_a = cfg_w[`ECC_CFG_PTR_A_MSB:`ECC_CFG_PTR_A_LSB];
      end
      if (avs_address_i == `ECC_OFS_COMMAND) begin
        // only a one is stored; zero leaves the pending request alone
        if (avs_byteenable_i[3] && avs_writedata_i[`ECC_CMD_CALC_BIT]) begin
          st_next.calc_req = 1'b1;
        end
        st_next.sign_b = cmd_w[`ECC_CMD_SIGN_B_BIT];
        st_next.sign_a = cmd_w[`ECC_CMD_SIGN_A_BIT];
        st_next.words = cmd_w[`ECC_CMD_SIZE_MSB:`ECC_CMD_SIZE_LSB];
        st_next.field = cmd_w[`ECC_CMD_FIELD_BIT];
        st_next.opcode = cmd_w[`ECC_CMD_OP_MSB:`ECC_CMD_OP_LSB];
      end
      // start while running is dropped: start is already high then
      if (avs_address_i == `ECC_OFS_CONTROL && avs_byteenable_i[0]
          && avs_writedata_i[`ECC_CTRL_START_BIT] && st_reg.st == ST_IDLE) begin
        st_next.start = 1'b1;
        st_next.done = 1'b0;
        st_next.err_op = 1'b0;
        st_next.err_size = 1'b0;
        st_next.st = ST_DISP;
      end
    end
  end

  // all block state in one register; clock enable freezes it
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_reg <= '0;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  assign busy_o = (st_reg.st != ST_IDLE);
  assign curve_param_a_negative_o = st_reg.sign_a;
  assign curve_param_b_negative_o = st_reg.sign_b;
  assign field_binary_o = st_reg.field;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  AST_RESULT_SLOT: assert property (
    (st_reg.st == ST_WS) |-> mem_bus.we && (mem_bus.addr[AW-1:LW] ==
      (st_reg.rmod_phase ? `ECC_SLOT_RMOD : st_reg.ptr_c)))
    else $error("result written outside the selected slot");
  AST_B_SLOT: assert property (
    (st_reg.st == ST_RB && !st_reg.rmod_phase) |-> mem_bus.addr[AW-1:LW] == st_reg.ptr_b)
    else $error("operand b read from wrong slot");
  AST_A_SLOT: assert property (
    (st_reg.st == ST_RA && !st_reg.rmod_phase) |-> mem_bus.addr[AW-1:LW] == st_reg.ptr_a)
    else $error("operand a read from wrong slot");
  AST_RMOD_FIRST: assert property (
    (ce_i && st_reg.st == ST_DISP && st_reg.calc_req && size_ok)
      |=> st_reg.st == ST_INIT && st_reg.rmod_phase)
    else $error("modulus pass not run before the operation");
  AST_CALC_CLEAR: assert property (
    $fell(st_reg.calc_req) |-> $past(st_reg.st) == ST_PEND && $past(st_reg.rmod_phase))
    else $error("recompute request cleared at the wrong time");
  AST_SIGNS: assert property (
    (acc && avs_write_i && avs_address_i == `ECC_OFS_COMMAND && avs_byteenable_i[3])
      |=> curve_param_b_negative_o == $past(avs_writedata_i[30])
        && curve_param_a_negative_o == $past(avs_writedata_i[29]))
    else $error("sign bits not taken from command write");
  AST_SIZE_FIELD: assert property (
    (acc && avs_write_i && avs_address_i == `ECC_OFS_COMMAND && avs_byteenable_i[1])
      |=> st_reg.words == $past(avs_writedata_i[15:8]))
    else $error("operand size not stored");
  AST_SIZE_LIMIT: assert property (
    (ce_i && st_reg.st == ST_DISP && !size_ok) |=> st_reg.st == ST_FIN && st_reg.err_size)
    else $error("oversize operand not refused");
  AST_BINARY_ADD: assert property (
    (st_reg.st == ST_WS && st_reg.field && !st_reg.rmod_phase)
      |-> mem_bus.wdata == (st_reg.op_a ^ st_reg.op_b))
    else $error("binary field result is not carry-less");
  AST_START_HELD: assert property (
    $fell(st_reg.start) |-> $past(st_reg.st) == ST_FIN && st_reg.st == ST_IDLE)
    else $error("start cleared before the operation finished");
  AST_BAD_OP: assert property (
    (ce_i && st_reg.st == ST_DISP && size_ok && !st_reg.calc_req && !op_ok)
      |=> st_reg.err_op ##1 !busy_o)
    else $error("unsupported operation not flagged");
  AST_RSV_ZERO: assert property (
    (acc && avs_read_i && avs_address_i == `ECC_OFS_COMMAND)
      |-> (avs_readdata_o & ~`ECC_CMD_MASK) == 32'h0000_0000)
    else $error("reserved command bits read non-zero");

  COV_ADD_DONE: cover property ($rose(st_reg.done) && !st_reg.err_op && !st_reg.err_size);
  COV_REDUCED: cover property (st_reg.st == ST_CW && !st_reg.rmod_phase);
  COV_RMOD: cover property ($fell(st_reg.calc_req));
  COV_BAD_OP: cover property ($rose(st_reg.err_op));
endmodule

/* inc/ecc_defs.svh */
`ifndef ECC_DEFS_SVH
`define ECC_DEFS_SVH
// register byte addresses
`define ECC_OFS_CONFIG 32'h5000_6000
`define ECC_OFS_COMMAND 32'h5000_6004
`define ECC_OFS_CONTROL 32'h5000_6008
`define ECC_OFS_STATUS 32'h5000_600c
`define ECC_OFS_VERSION 32'h5000_6010
// writable bits; everything else reads zero
`define ECC_CFG_MASK 32'h001f_1f1f
`define ECC_CMD_MASK 32'he000_ffff
`define ECC_RST_CONFIG 32'h0000_0000
`define ECC_RST_COMMAND 32'h0000_0000
// configuration fields
`define ECC_CFG_PTR_C_MSB 20
`define ECC_CFG_PTR_C_LSB 16
`define ECC_CFG_PTR_B_MSB 12
`define ECC_CFG_PTR_B_LSB 8
`define ECC_CFG_PTR_A_MSB 4
`define ECC_CFG_PTR_A_LSB 0
// command fields
`define ECC_CMD_CALC_BIT 31
`define ECC_CMD_SIGN_B_BIT 30
`define ECC_CMD_SIGN_A_BIT 29
`define ECC_CMD_SIZE_MSB 15
`define ECC_CMD_SIZE_LSB 8
`define ECC_CMD_FIELD_BIT 7
`define ECC_CMD_OP_MSB 6
`define ECC_CMD_OP_LSB 0
// control and status bits
`define ECC_CTRL_START_BIT 0
`define ECC_STAT_BUSY_BIT 0
`define ECC_STAT_DONE_BIT 1
`define ECC_STAT_ERR_OP_BIT 2
`define ECC_STAT_ERR_SIZE_BIT 3
// operation codes
`define ECC_OP_MOD_ADD 7'h01
`define ECC_OP_MOD_SUB 7'h02
// reserved memory slots
`define ECC_SLOT_RMOD 5'h1d
`define ECC_SLOT_MOD 5'h1e
`define ECC_SLOT_SCRATCH 5'h1f
// sizes and identity
`define ECC_BITS_PER_WORD 16'h0040
`define ECC_MAX_LOG2_DEF 3
`define ECC_VERSION_DEF 32'h0001_0000
`endif

/* inc/ecc_pkg.sv */
package ecc_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_DISP, ST_INIT, ST_RA, ST_RB, ST_RN, ST_WS, ST_WD, ST_CR, ST_CW, ST_PEND, ST_FIN
  } ecc_eng_state_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [4:0] ptr_c;
    logic [4:0] ptr_b;
    logic [4:0] ptr_a;
    logic calc_req;
    logic sign_b;
    logic sign_a;
    logic [7:0] words;
    logic field;
    logic [6:0] opcode;
    logic start;
    logic done;
    logic err_op;
    logic err_size;
    ecc_eng_state_t st;
    logic rmod_phase;
    logic [7:0] word;
    logic [15:0] dbl_cnt;
    logic [63:0] op_a;
    logic [63:0] op_b;
    logic [63:0] d_word;
    logic carry_s;
    logic carry_d;
  } ecc_state_t;
endpackage

/* inc/ecc_mem_if.sv */
`timescale 1ns/100ps
interface ecc_mem_if #(parameter int AW = 8);
  logic en;
  logic we;
  logic [AW-1:0] addr;
  logic [63:0] wdata;
  logic [63:0] rdata;
  modport ctrl (output en, output we, output addr, output wdata, input rdata);
  modport mem (input en, input we, input addr, input wdata, output rdata);
endinterface

/* hw/ecc_word_alu.sv */
`timescale 1ns/100ps
// one 64-bit limb of a multi-word add, subtract or carry-less add
module ecc_word_alu #(
  parameter int W = 64
) (
  input wire logic [W-1:0] a_i,
  input wire logic [W-1:0] b_i,
  input wire logic cin_i,
  input wire logic sub_i,
  input wire logic xor_i,
  output logic [W-1:0] y_o,
  output logic cout_o
);
  logic [W:0] t;

  // borrow leaves through bit W on subtract, carry on add
  always_comb begin
    t = '0;
    if (xor_i) begin
      t = {1'b0, a_i ^ b_i};
    end else if (sub_i) begin
      t = {1'b0, a_i} - {1'b0, b_i} - {{W{1'b0}}, cin_i};
    end else begin
      t = {1'b0, a_i} + {1'b0, b_i} + {{W{1'b0}}, cin_i};
    end
    y_o = t[W-1:0];
    cout_o = xor_i ? 1'b0 : t[W];
  end
endmodule

/* hw/ecc_mem.sv */
`timescale 1ns/100ps
// crypto memory: engine port plus a load port for software operands
module ecc_mem #(
  parameter int AW = 8
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  ecc_mem_if.mem eng,
  input wire logic ld_en_i,
  input wire logic ld_we_i,
  input wire logic [AW-1:0] ld_addr_i,
  input wire logic [63:0] ld_wdata_i,
  output logic [63:0] ld_rdata_o
);
  logic [63:0] mem_array [0:(1<<AW)-1];
  logic [63:0] eng_rdata_reg;
  logic [63:0] ld_rdata_reg;

  // array itself has no reset; the engine write wins a same-address collision
  always_ff @(posedge sys_clk_i) begin
    if (ce_i) begin
      if (ld_en_i && ld_we_i) begin
        mem_array[ld_addr_i] <= ld_wdata_i;
      end
      if (eng.en && eng.we) begin
        mem_array[eng.addr] <= eng.wdata;
      end
    end
  end

  // registered read data on both ports
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      eng_rdata_reg <= 64'h0;
      ld_rdata_reg <= 64'h0;
    end else if (ce_i) begin
      if (eng.en) begin
        eng_rdata_reg <= mem_array[eng.addr];
      end
      if (ld_en_i) begin
        ld_rdata_reg <= mem_array[ld_addr_i];
      end
    end
  end

  assign eng.rdata = eng_rdata_reg;
  assign ld_rdata_o = ld_rdata_reg;
endmodule

/* tb/tb_ecc_cmd_top.sv */
`timescale 1ns/100ps
`include "ecc_defs.svh"
module tb_ecc_cmd_top;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [31:0] avs_address = 32'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic ld_en = 1'b0;
  logic ld_we = 1'b0;
  logic [7:0] ld_addr = 8'h00;
  logic [63:0] ld_wdata = 64'h0;
  logic [63:0] ld_rdata;
  logic busy, sign_a, sign_b, field_bin;
  int mismatches = 0;
  int checked = 0;
  logic [31:0] rd;
  // refused commands and the status bits {err_size, err_op} each must raise
  logic [31:0] ecmd [4] = '{32'h0000_0001, 32'h0000_0901, 32'h0000_0103, 32'h0000_0100};
  logic [1:0] eexp [4] = '{2'h2, 2'h2, 2'h1, 2'h1};

  ecc_cmd_top #(.MAX_OPERAND_SIZE_PARAM(3)) ecc_cmd_top_inst (
    .sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .ce_i(1'b1),
    .avs_address_i(avs_address), .avs_read_i(avs_read), .avs_write_i(avs_write),
    .avs_writedata_i(avs_writedata), .avs_byteenable_i(avs_byteenable),
    .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest),
    .ld_en_i(ld_en), .ld_we_i(ld_we), .ld_addr_i(ld_addr), .ld_wdata_i(ld_wdata),
    .ld_rdata_o(ld_rdata), .busy_o(busy), .curve_param_a_negative_o(sign_a),
    .curve_param_b_negative_o(sign_b), .field_binary_o(field_bin)
  );

  // 100 mhz system clock
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  task report_and_stop;
    if (mismatches == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one avalon cycle; the request is held until waitrequest is seen low
  task bus(input logic wr_i, input logic [31:0] a, input logic [31:0] d,
           input logic [3:0] be, output logic [31:0] q);
    int n;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr_i;
    avs_read <= ~wr_i;
    n = 0;
    // waitrequest and read data are taken as they stand at each rising edge
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      if (n > 50) begin
        mismatches++;
        report_and_stop();
      end
      @(posedge sys_clk);
    end
    q = avs_readdata; // read data stands at the completing edge
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf, rd);
  endtask

  task rchk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hf, rd);
    check({32'h0, rd}, {32'h0, exp});
  endtask

  // load port: address is {slot, word} with 8 words per slot
  task ldw(input logic [4:0] s, input logic [2:0] w, input logic [63:0] d);
    @(posedge sys_clk);
    ld_en <= 1'b1;
    ld_we <= 1'b1;
    ld_addr <= {s, w};
    ld_wdata <= d;
    @(posedge sys_clk);
    ld_en <= 1'b0;
    ld_we <= 1'b0;
  endtask

  task ldchk(input logic [4:0] s, input logic [2:0] w, input logic [63:0] exp);
    @(posedge sys_clk);
    ld_en <= 1'b1;
    ld_addr <= {s, w};
    @(posedge sys_clk);
    ld_en <= 1'b0;
    @(negedge sys_clk);
    check(ld_rdata, exp);
  endtask

  // program, start and poll until done; an error bit rises a cycle before done
  task run(input logic [31:0] cfg, input logic [31:0] cmd);
    int n;
    wr(`ECC_OFS_CONFIG, cfg);
    wr(`ECC_OFS_COMMAND, cmd);
    wr(`ECC_OFS_CONTROL, 32'h0000_0001);
    n = 0;
    rd = 32'h0; // drop stale read data from an earlier status read
    while ((rd & 32'h0000_0002) == 32'h0) begin
      n++;
      if (n > 3000) begin
        mismatches++;
        report_and_stop();
      end
      bus(1'b0, `ECC_OFS_STATUS, 32'h0, 4'hf, rd);
    end
  endtask

  // main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rchk(`ECC_OFS_CONFIG, 32'h0000_0000);
    rchk(`ECC_OFS_COMMAND, 32'h0000_0000);
    rchk(32'h5000_6014, 32'h0000_0000);
    bus(1'b1, `ECC_OFS_CONFIG, 32'hffff_ffff, 4'h1, rd);
    rchk(`ECC_OFS_CONFIG, 32'h0000_001f);
    wr(`ECC_OFS_CONFIG, 32'hffff_ffff);
    rchk(`ECC_OFS_CONFIG, 32'h001f_1f1f);
    wr(`ECC_OFS_COMMAND, 32'hffff_ffff);
    rchk(`ECC_OFS_COMMAND, 32'he000_ffff);
    check({61'h0, sign_a, sign_b, field_bin}, 64'h7);
    wr(`ECC_OFS_COMMAND, 32'h0000_0000);
    rchk(`ECC_OFS_COMMAND, 32'h8000_0000);
    check({61'h0, sign_a, sign_b, field_bin}, 64'h0);
    // modulus 100 in slot 30; the pending recompute runs before the add
    ldw(5'h1e, 3'h0, 64'h64);
    ldw(5'h02, 3'h0, 64'h5);
    ldw(5'h03, 3'h0, 64'h7);
    run(32'h0004_0302, 32'h0000_0101);
    check({61'h0, rd[3:1]}, 64'h1);
    check({63'h0, busy}, 64'h0);
    rchk(`ECC_OFS_COMMAND, 32'h0000_0101);
    rchk(`ECC_OFS_CONTROL, 32'h0000_0000);
    ldchk(5'h1d, 3'h0, 64'h10);
    ldchk(5'h04, 3'h0, 64'hc);
    run(32'h0004_0302, 32'h0000_0102);
    ldchk(5'h04, 3'h0, 64'h62);
    run(32'h0004_0302, 32'h0000_0181);
    ldchk(5'h04, 3'h0, 64'h2);
    // two limbs: carry must cross from word 0 into word 1
    ldw(5'h1e, 3'h0, 64'h0);
    ldw(5'h1e, 3'h1, 64'h2);
    ldw(5'h06, 3'h0, 64'hffff_ffff_ffff_ffff);
    ldw(5'h06, 3'h1, 64'h0);
    ldw(5'h07, 3'h0, 64'h1);
    ldw(5'h07, 3'h1, 64'h0);
    run(32'h0008_0706, 32'h8000_0201);
    ldchk(5'h08, 3'h0, 64'h0);
    ldchk(5'h08, 3'h1, 64'h1);
    // three limbs behind a new modulus top word: recompute, then a prime-field add
    ldw(5'h1e, 3'h2, 64'h8);
    ldw(5'h06, 3'h2, 64'h0);
    ldw(5'h07, 3'h0, 64'h2);
    ldw(5'h07, 3'h2, 64'h5);
    run(32'h0008_0706, 32'h8000_0301);
    check({61'h0, rd[3:1]}, 64'h1);
    ldchk(5'h08, 3'h0, 64'h1);
    ldchk(5'h08, 3'h2, 64'h5);
    // refused sizes and codes leave the result slot alone
    for (int i = 0; i < 4; i++) begin
      run(32'h0004_0706, ecmd[i]);
      check({61'h0, rd[3:2], rd[0]}, {61'h0, eexp[i], 1'b0});
    end
    ldchk(5'h04, 3'h0, 64'h2);
    report_and_stop();
  end
endmodule
